// *** pkg/vpic_pkg.sv ***
// vpic_pkg: constants and types of the vectored priority interrupt controller
`default_nettype none
package vpic_pkg;

	// ==========================================================
	// register offsets and fields
	localparam logic [3:0] OFS_SI_STATUS = 4'h0; // system_integrity_status
	localparam logic [3:0] OFS_EXT_SENS  = 4'h1;
	localparam logic [3:0] OFS_EN_LO     = 4'h2;
	localparam logic [3:0] OFS_EN_HI     = 4'h3;
	localparam logic [3:0] OFS_PEND_LO   = 4'h4;
	localparam logic [3:0] OFS_PEND_HI   = 4'h5;
	localparam logic [3:0] OFS_CORE_STAT = 4'h6;

	localparam int unsigned SIS_ENABLE_BIT = 0; // supply_warning_irq_enable
	localparam int unsigned SIS_FLAG_BIT   = 1; // supply_warning_flag
	localparam int unsigned STAT_MASK_BIT  = 0;
	localparam int unsigned STAT_IRQ_BIT   = 1;
	localparam int unsigned STAT_IDX_POS   = 4;

	// ==========================================================
	// reset values
	localparam logic [7:0]  SENS_RST   = 8'h00;
	localparam logic [13:0] EN_RST     = 14'h0000;
	localparam logic        MASK_RST   = 1'h1;
	localparam logic [3:0]  LINE_RST   = 4'hf;

	// ==========================================================
	// sources, sets and vectors
	localparam int unsigned NUM_SRC     = 14;
	localparam int unsigned SRC_EXT0    = 1;
	localparam logic [3:0]  SRC_SUPPLY  = 4'h7;
	localparam logic [3:0]  TRAP_INDEX  = 4'hf;
	localparam logic [13:0] EXT_SET     = 14'h001e;
	localparam logic [13:0] SUPPLY_SET  = 14'h0080;
	localparam logic [13:0] PERIPH_SET  = 14'h3f61;
	localparam logic [13:0] HALT_SET    = 14'h101e; // ext lines and spi
	localparam logic [13:0] AWU_SET     = 14'h0001;
	localparam logic [13:0] ACTIVE_SET  = 14'h0a00; // sources 9 and 11
	localparam logic [15:0] VEC_RESET   = 16'hfffe;
	localparam logic [15:0] VEC_TRAP    = 16'hfffc;
	localparam logic [15:0] VEC_SRC0    = 16'hfffa;

	// sensitivity codes of an external line
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE     = 2'h1;
	localparam logic [1:0] SENS_FALL     = 2'h2;
	localparam logic [1:0] SENS_BOTH     = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		VPIC_HALT_PLAIN,
		VPIC_HALT_ACTIVE,
		VPIC_HALT_AWU
	} vpic_halt_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vpic_bus_s;

	typedef struct packed {
		logic        mask;      // global interrupt mask
		logic [7:0]  sens;
		logic        sw_en;     // supply_warning_irq_enable
		logic [13:0] periph_en;
		logic [13:0] pend;      // request latches
		logic [13:0] flag_q;
		logic [3:0]  line_q;
		logic        supply_q;
		logic        trap_pend;
		logic        irq;
		logic [3:0]  index;
		logic [15:0] vector;
		logic [7:0]  rdata;
	} vpic_state_s;

endpackage
`default_nettype wire

// *** logic/vpic_ctrl.sv ***
// vpic_ctrl: vectored fixed-priority interrupt controller with wake-up decode
// Operation
// - maskable requests reach the core only while global mask clear; latched otherwise.
// - after reset all maskable sources disabled and global mask set; ext lines 1 to 4 have no enable bit and stay enabled.
// - core finishes current instruction and stacks registers before accepting vector.
// - accepting a vector sets the global mask; core loads vector into pc.
// - return from interrupt restores registers, leaving the global mask clear.
// - fixed priority: reset, trap, then sources 0 to 13, 13 lowest.
// - two-byte vectors: reset fffe, trap fffc, source 13 at ffe0.
// - trap always taken regardless of mask, same stacking and vectoring.
// - every source wakes wait; only reset, ext lines, spi wake halt.
// - source 0 wakes only from auto wakeup halt mode.
// - sources 9 and 11 wake only from active halt.
// - edge external request latched, cleared when its routine is entered.
// - external vector only when fired and mask clear; ext lines wake halt.
// - peripheral flag requests only with mask clear and enable set, else pending.
// - clearing sequence resets the request latch, discarding a disabled pending one.
// - supply warning rising with enable set requests source 7.
// - supply enable bit 0 is software read-write; pending clears on entry.
// - supply flag bit 1 is read-only, one while supply under threshold.
// - programmed sensitivity decides when each external request is generated.
// - code 00 falling and low, 01 rising, 10 falling, 11 both.
// - entering wait clears the global mask.
// - supply warning may end wait but never halt.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module vpic_ctrl (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_sys_rst,
	input  wire vpic_pkg::vpic_bus_s    i_bus,
	output logic [7:0]                  o_rdata,
	input  wire logic [3:0]             i_ext_line,
	input  wire logic [13:0]            i_periph_flag,
	input  wire logic [13:0]            i_periph_clr,
	input  wire logic                   i_supply_low,
	input  wire logic                   i_trap,
	input  wire logic                   i_vec_ack,
	input  wire logic                   i_return_from_interrupt,
	input  wire logic                   i_mask_set,
	input  wire logic                   i_mask_clr,
	input  wire logic                   i_wait_entry,
	input  wire logic                   i_halt_entry,
	input  wire vpic_pkg::vpic_halt_e   i_halt_mode,
	output logic                        o_irq_req,
	output logic [3:0]                  o_irq_index,
	output logic [15:0]                 o_vector,
	output logic                        o_global_mask,
	output logic                        o_wake_wait,
	output logic                        o_wake_halt
);

	// ==========================================================
	// state
	vpic_pkg::vpic_state_s st;
	vpic_pkg::vpic_state_s next_st;

	logic [13:0] req_cur;
	logic [13:0] req_next;
	logic [13:0] halt_set;
	logic [13:0] ext_hit;
	logic [13:0] periph_rise;
	logic [13:0] ack_clr;
	logic        accept;
	logic        supply_rise;
	logic [3:0]  sel;
	logic        any_req;

	// enabled requests of a state, with level sensing of code 00
	function automatic logic [13:0] f_req(
		input vpic_pkg::vpic_state_s s,
		input logic [3:0]            line
	);
		logic [13:0] lvl;
		logic [13:0] en;
		lvl = '0;
		for (int k = 0; k < 4; k++) begin
			if (s.sens[2*k +: 2] == vpic_pkg::SENS_FALL_LOW && !line[k]) begin
				lvl[vpic_pkg::SRC_EXT0 + k] = 1'b1;
			end
		end
		en = (s.periph_en & vpic_pkg::PERIPH_SET) | vpic_pkg::EXT_SET;
		if (s.sw_en) begin
			en = en | vpic_pkg::SUPPLY_SET;
		end
		return (s.pend | lvl) & en;
	endfunction

	// ==========================================================
	// edge detection
	// a line high at reset release does not fake a falling edge
	always_comb begin
		ext_hit = '0;
		for (int k = 0; k < 4; k++) begin
			case (st.sens[2*k +: 2])
				vpic_pkg::SENS_FALL_LOW: ext_hit[vpic_pkg::SRC_EXT0 + k] =
					st.line_q[k] & ~i_ext_line[k];
				vpic_pkg::SENS_RISE: ext_hit[vpic_pkg::SRC_EXT0 + k] =
					~st.line_q[k] & i_ext_line[k];
				vpic_pkg::SENS_FALL: ext_hit[vpic_pkg::SRC_EXT0 + k] =
					st.line_q[k] & ~i_ext_line[k];
				default: ext_hit[vpic_pkg::SRC_EXT0 + k] =
					st.line_q[k] ^ i_ext_line[k];
			endcase
		end
	end

	// peripheral flags latch on their rising edge, enabled or not
	assign periph_rise = i_periph_flag & ~st.flag_q & vpic_pkg::PERIPH_SET;
	assign supply_rise = i_supply_low & ~st.supply_q & st.sw_en;
	assign accept      = i_vec_ack & st.irq;
	assign ack_clr     = accept ? (14'h1 << st.index) : 14'h0;

	// ==========================================================
	// next state
	always_comb begin
		next_st          = st;
		next_st.line_q   = i_ext_line;
		next_st.flag_q   = i_periph_flag;
		next_st.supply_q = i_supply_low;
		next_st.rdata    = 8'h00;

		// latches: clears first, so a same-cycle event still sets
		next_st.pend = st.pend & ~ack_clr;
		next_st.pend = next_st.pend & ~(i_periph_clr & vpic_pkg::PERIPH_SET);
		next_st.pend = next_st.pend | ext_hit | periph_rise;
		if (supply_rise) begin
			next_st.pend = next_st.pend | vpic_pkg::SUPPLY_SET;
		end

		// trap pends until the core takes its vector
		if (accept && st.index == vpic_pkg::TRAP_INDEX) begin
			next_st.trap_pend = 1'b0;
		end
		if (i_trap) begin
			next_st.trap_pend = 1'b1;
		end

		// global mask: every set wins over every clear
		if (i_return_from_interrupt || i_mask_clr) begin
			next_st.mask = 1'b0;
		end
		if (i_wait_entry || i_halt_entry) begin
			next_st.mask = 1'b0;
		end
		if (i_mask_set || accept) begin
			next_st.mask = 1'b1;
		end

		// register writes
		if (i_bus.wr) begin
			case (i_bus.addr)
				vpic_pkg::OFS_SI_STATUS: next_st.sw_en =
					i_bus.wdata[vpic_pkg::SIS_ENABLE_BIT];
				vpic_pkg::OFS_EXT_SENS: begin
					// sensitivity only changes while interrupts are masked
					if (st.mask) begin
						next_st.sens = i_bus.wdata;
					end
				end
				vpic_pkg::OFS_EN_LO: next_st.periph_en[7:0] =
					i_bus.wdata & vpic_pkg::PERIPH_SET[7:0];
				vpic_pkg::OFS_EN_HI: next_st.periph_en[13:8] =
					i_bus.wdata[5:0] & vpic_pkg::PERIPH_SET[13:8];
				default: next_st.sw_en = st.sw_en;
			endcase
		end

		// register reads, valid in the following cycle only
		if (i_bus.rd) begin
			case (i_bus.addr)
				vpic_pkg::OFS_SI_STATUS: begin
					next_st.rdata[vpic_pkg::SIS_ENABLE_BIT] = st.sw_en;
					next_st.rdata[vpic_pkg::SIS_FLAG_BIT]   = i_supply_low;
				end
				vpic_pkg::OFS_EXT_SENS: next_st.rdata = st.sens;
				vpic_pkg::OFS_EN_LO: next_st.rdata = st.periph_en[7:0];
				vpic_pkg::OFS_EN_HI: next_st.rdata = {2'h0, st.periph_en[13:8]};
				vpic_pkg::OFS_PEND_LO: next_st.rdata = st.pend[7:0];
				vpic_pkg::OFS_PEND_HI: next_st.rdata = {2'h0, st.pend[13:8]};
				vpic_pkg::OFS_CORE_STAT: begin
					next_st.rdata[vpic_pkg::STAT_MASK_BIT] = st.mask;
					next_st.rdata[vpic_pkg::STAT_IRQ_BIT]  = st.irq;
					next_st.rdata[vpic_pkg::STAT_IDX_POS +: 4] = st.index;
				end
				default: next_st.rdata = 8'h00;
			endcase
		end

		// selection on the updated state so outputs never go stale
		// after an acceptance
		req_next = f_req(next_st, i_ext_line);
		sel      = 4'h0;
		any_req  = |req_next;
		for (int i = vpic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (req_next[i]) begin
				sel = 4'(i);
			end
		end
		if (next_st.trap_pend) begin
			next_st.irq    = 1'b1;
			next_st.index  = vpic_pkg::TRAP_INDEX;
			next_st.vector = vpic_pkg::VEC_TRAP;
		end else if (any_req && !next_st.mask) begin
			next_st.irq    = 1'b1;
			next_st.index  = sel;
			next_st.vector = vpic_pkg::VEC_SRC0 - {11'h0, sel, 1'b0};
		end else begin
			next_st.irq    = 1'b0;
			next_st.index  = 4'h0;
			next_st.vector = vpic_pkg::VEC_RESET;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st           <= '0;
			st.mask      <= vpic_pkg::MASK_RST;
			st.sens      <= vpic_pkg::SENS_RST;
			st.periph_en <= vpic_pkg::EN_RST;
			st.line_q    <= vpic_pkg::LINE_RST;
			st.vector    <= vpic_pkg::VEC_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// wake-up decode
	// reset wakes by itself through the reset path
	assign req_cur = f_req(st, i_ext_line);

	always_comb begin
		halt_set = vpic_pkg::HALT_SET;
		case (i_halt_mode)
			vpic_pkg::VPIC_HALT_AWU: halt_set = halt_set | vpic_pkg::AWU_SET;
			vpic_pkg::VPIC_HALT_ACTIVE: halt_set = halt_set | vpic_pkg::ACTIVE_SET;
			default: halt_set = vpic_pkg::HALT_SET;
		endcase
	end

	assign o_wake_wait   = (|req_cur) | st.trap_pend;
	assign o_wake_halt   = |(req_cur & halt_set);
	assign o_rdata       = st.rdata;
	assign o_irq_req     = st.irq;
	assign o_irq_index   = st.index;
	assign o_vector      = st.vector;
	assign o_global_mask = st.mask;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_accept;
		i_vec_ack && st.irq;
	endsequence

	sequence s_no_unmask;
		!i_return_from_interrupt && !i_mask_clr && !i_wait_entry && !i_halt_entry;
	endsequence

	a_masked_silent: assert property (
		(o_irq_req && o_irq_index != vpic_pkg::TRAP_INDEX) |-> !o_global_mask
	) else $error("maskable request shown while masked");

	a_accept_masks: assert property (
		s_accept |=> o_global_mask
	) else $error("mask not set after vector acceptance");

	a_mask_holds: assert property (
		(o_global_mask and s_no_unmask) |=> o_global_mask
	) else $error("mask dropped without a cause");

	a_return_from_interrupt_unmask: assert property (
		(i_return_from_interrupt && !i_mask_set && !i_vec_ack) |=> !o_global_mask
	) else $error("mask still set after return");

	a_wait_unmask: assert property (
		(i_wait_entry && !i_mask_set && !i_vec_ack) |=> !o_global_mask
	) else $error("mask still set after wait entry");

	a_vector_map: assert property (
		(o_irq_req && o_irq_index != vpic_pkg::TRAP_INDEX) |->
		o_vector == vpic_pkg::VEC_SRC0 - {11'h0, o_irq_index, 1'b0}
	) else $error("vector does not match source");

	// the trap shows in the cycle after it, whatever the mask holds
	a_trap_taken: assert property (
		i_trap |=> (o_irq_req && o_irq_index == vpic_pkg::TRAP_INDEX
			&& o_vector == vpic_pkg::VEC_TRAP)
	) else $error("trap not presented");

	a_priority_low: assert property (
		(o_irq_req && o_irq_index != vpic_pkg::TRAP_INDEX) |->
		(req_cur & ((14'h1 << o_irq_index) - 14'h1)) == 14'h0
	) else $error("lower-priority source selected");

	a_supply_clear: assert property (
		(s_accept ##0 (o_irq_index == vpic_pkg::SRC_SUPPLY) ##0 !supply_rise)
		|=> !st.pend[vpic_pkg::SRC_SUPPLY]
	) else $error("supply pending not cleared on entry");

	a_supply_no_halt: assert property (
		(req_cur == vpic_pkg::SUPPLY_SET) |-> !o_wake_halt
	) else $error("supply warning woke from halt");

	a_sens_locked: assert property (
		(i_bus.wr && i_bus.addr == vpic_pkg::OFS_EXT_SENS && !o_global_mask)
		|=> $stable(st.sens)
	) else $error("sensitivity changed while unmasked");

endmodule
`default_nettype wire

// *** testbench/vpic_core_model.sv ***
// vpic_core_model: behavioural cpu core that takes vectors and returns from handlers
`timescale 1ns/1ps
`default_nettype none

module vpic_core_model #(
	parameter int STACK_CYC = 3,
	parameter int ISR_CYC   = 4
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_irq_req,
	input  wire logic [3:0]  i_irq_index,
	input  wire logic [15:0] i_vector,
	output logic             o_vec_ack,
	output logic             o_return_from_interrupt,
	output logic [3:0]       o_taken_index,
	output logic [15:0]      o_taken_vector,
	output logic [7:0]       o_taken_cnt
);
	// ==========================================================
	// run, stack and service phases
	logic [1:0] phase;
	logic [7:0] cnt;

	// ack only once the instruction ends and context is stacked, so a request dropped before then is abandoned
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			phase          <= 2'd0;
			cnt            <= 8'h00;
			o_vec_ack      <= 1'b0;
			o_return_from_interrupt         <= 1'b0;
			o_taken_index  <= 4'h0;
			o_taken_vector <= 16'h0000;
			o_taken_cnt    <= 8'h00;
		end else begin
			o_vec_ack <= 1'b0;
			o_return_from_interrupt    <= 1'b0;
			cnt       <= cnt + 8'h01;
			case (phase)
				2'd0: begin
					cnt   <= 8'h00;
					phase <= {1'b0, i_irq_req};
				end
				2'd1: begin
					if (!i_irq_req) begin
						phase <= 2'd0;
					end else if (cnt == 8'(STACK_CYC)) begin
						o_vec_ack <= 1'b1;
						cnt       <= 8'h00;
						phase     <= 2'd2;
					end
				end
				default: begin
					if (o_vec_ack && i_irq_req) begin
						o_taken_index  <= i_irq_index;
						o_taken_vector <= i_vector;
						o_taken_cnt    <= o_taken_cnt + 8'h01;
					end
					if (o_vec_ack && !i_irq_req) begin
						phase <= 2'd0;
					end else if (cnt == 8'(ISR_CYC)) begin
						o_return_from_interrupt <= 1'b1;
						phase  <= 2'd0;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** testbench/vectored_priority_irq_controller_bench.sv ***
// vectored_priority_irq_controller_bench: self-checking bench of vpic_ctrl
`timescale 1ns/1ps
`default_nettype none

module vectored_priority_irq_controller_bench;
	// ==========================================================
	// stimulus and observed signals
	logic                 clk;
	logic                 rst;
	vpic_pkg::vpic_bus_s  bus;
	vpic_pkg::vpic_halt_e hmode;
	logic [3:0]           line, idx, t_idx;
	logic [13:0]          flag, pclr;
	logic [15:0]          vec, t_vec;
	logic [7:0]           rdata, t_cnt, exp_n, d;
	logic                 sup_low, trap, ack, return_from_interrupt, mset, mclr, wt_in, ht_in;
	logic                 irq, mask, wk_wait, wk_halt;
	int                   n_errors, samples_checked;

	// free-running core clock
	always #20 clk = ~clk;

	vpic_ctrl dut (.i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata),
		.i_ext_line(line), .i_periph_flag(flag), .i_periph_clr(pclr), .i_supply_low(sup_low),
		.i_trap(trap), .i_vec_ack(ack), .i_return_from_interrupt(return_from_interrupt), .i_mask_set(mset), .i_mask_clr(mclr),
		.i_wait_entry(wt_in), .i_halt_entry(ht_in), .i_halt_mode(hmode), .o_irq_req(irq),
		.o_irq_index(idx), .o_vector(vec), .o_global_mask(mask), .o_wake_wait(wk_wait),
		.o_wake_halt(wk_halt));

	vpic_core_model core (.i_core_clk(clk), .i_sys_rst(rst), .i_irq_req(irq),
		.i_irq_index(idx), .i_vector(vec), .o_vec_ack(ack), .o_return_from_interrupt(return_from_interrupt),
		.o_taken_index(t_idx), .o_taken_vector(t_vec), .o_taken_cnt(t_cnt));

	// ==========================================================
	// shared tasks, entered just after a rising edge, except chk, which is also called mid-cycle
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask

	localparam int P_TRAP = 0;
	localparam int P_MSET = 1;
	localparam int P_MCLR = 2;
	localparam int P_WAIT = 3;
	localparam int P_HALT = 4;

	// one-cycle pulse on a core event line chosen by code; a ref target cannot take <=
	task automatic pulse(input int which);
		case (which)
			P_TRAP: trap <= 1'b1;
			P_MSET: mset <= 1'b1;
			P_MCLR: mclr <= 1'b1;
			P_WAIT: wt_in <= 1'b1;
			default: ht_in <= 1'b1;
		endcase
		@(posedge clk);
		{trap, mset, mclr, wt_in, ht_in} <= 5'h00;
		@(posedge clk);
	endtask

	// the core acks on its own; wait bounded for the next taken vector and judge it
	task automatic taken(input logic [3:0] ei, input logic [15:0] ev);
		int k;
		exp_n++;
		// look at mid-cycle, where the model's counters have settled
		for (k = 0; k < 60 && t_cnt != exp_n; k++) @(negedge clk);
		chk("taken count", exp_n, t_cnt);
		chk("taken index", ei, t_idx);
		chk("taken vector", ev, t_vec);
		chk("mask in handler", 1, mask);
		repeat (10) @(posedge clk);
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk("mask", 1, mask);
		chk("irq", 0, irq);
		rd(vpic_pkg::OFS_EN_LO, d);
		chk("en_lo", 0, d);
		rd(vpic_pkg::OFS_CORE_STAT, d);
		chk("core_stat", 8'h01, d);
		wr(vpic_pkg::OFS_SI_STATUS, 8'h03);
		rd(vpic_pkg::OFS_SI_STATUS, d);
		chk("si_status", 8'h01, d);
	endtask

	task automatic t_trap;
		pulse(P_TRAP);
		taken(vpic_pkg::TRAP_INDEX, 16'hfffc);
		chk("mask after return", 0, mask);
	endtask

	task automatic t_supply;
		pulse(P_MSET);
		pulse(P_MCLR);
		sup_low <= 1'b1;
		taken(4'h7, 16'hffec);
		rd(vpic_pkg::OFS_SI_STATUS, d);
		chk("si_status low", 8'h03, d);
		chk("supply irq gone", 0, irq);
		sup_low <= 1'b0;
	endtask

	task automatic t_periph;
		int m;
		pulse(P_MSET);
		wr(vpic_pkg::OFS_EN_LO, 8'h20);
		wr(vpic_pkg::OFS_EN_HI, 8'h22);
		flag <= 14'h2260;
		repeat (3) @(posedge clk);
		chk("masked irq", 0, irq);
		rd(vpic_pkg::OFS_PEND_LO, d);
		chk("pend_lo", 8'h60, d);
		rd(vpic_pkg::OFS_PEND_HI, d);
		chk("pend_hi", 8'h22, d);
		chk("wake wait", 1, wk_wait);
		for (m = 0; m < 3; m++) begin
			hmode <= vpic_pkg::vpic_halt_e'(m);
			@(negedge clk);
			chk("wake halt", m == 1, wk_halt);
			@(posedge clk);
		end
		pclr <= 14'h0040;
		@(posedge clk);
		pclr <= 14'h0000;
		rd(vpic_pkg::OFS_PEND_LO, d);
		chk("pend after clear", 8'h20, d);
		pulse(P_WAIT);
		taken(4'h5, 16'hfff0);
		taken(4'h9, 16'hffe8);
		taken(4'hd, 16'hffe0);
		chk("mask idle", 0, mask);
	endtask

	task automatic t_ext;
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			pulse(P_MSET);
			wr(vpic_pkg::OFS_EXT_SENS, {6'h00, c});
			line <= 4'he;
			repeat (3) @(posedge clk);
			rd(vpic_pkg::OFS_PEND_LO, d);
			chk("pend on fall", c != 2'd1, d[1]);
			line <= 4'hf;
			repeat (3) @(posedge clk);
			rd(vpic_pkg::OFS_PEND_LO, d);
			chk("pend on rise", 1, d[1]);
			pulse(P_HALT);
			taken(4'h1, 16'hfff8);
			rd(vpic_pkg::OFS_PEND_LO, d);
			chk("pend after entry", 0, d[1]);
		end
		// mask is clear again here, so a sensitivity write must be ignored
		wr(vpic_pkg::OFS_EXT_SENS, 8'hff);
		rd(vpic_pkg::OFS_EXT_SENS, d);
		chk("sens locked", 8'h03, d);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		line = 4'hf;
		flag = '0;
		pclr = '0;
		{sup_low, trap, mset, mclr, wt_in, ht_in} = '0;
		hmode = vpic_pkg::VPIC_HALT_PLAIN;
		n_errors = 0;
		samples_checked = 0;
		exp_n = 8'h00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_trap();
		t_supply();
		t_periph();
		t_ext();
		end_of_test();
	end

	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
